// ### core/flash_page_erase_byte_write.sv
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module flash_page_erase_byte_write
  import flash_seq_pkg::*;
(
  input wire logic clk_i, // System clock, 50 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic cyc_i, // Wishbone cycle.
  input wire logic stb_i, // Wishbone strobe.
  input wire logic we_i, // Wishbone write enable.
  input wire logic [31:0] adr_i, // Wishbone byte address.
  input wire logic [3:0] sel_i, // Wishbone byte selects.
  input wire logic [31:0] dat_i, // Wishbone write data.
  output logic [31:0] dat_o, // Wishbone read data.
  output logic ack_o, // Wishbone acknowledge.
  output logic xdata_we_o, // One-cycle write strobe to data memory.
  output logic [FLASH_AW-1:0] xdata_addr_o, // Data memory address.
  output logic [7:0] xdata_data_o, // Data memory write data.
  output logic store_write_enable_o, // Current store-write enable.
  output logic flash_busy_o // Flash program or erase in progress.
);

  typedef struct packed {
    logic store_write_enable;
    logic page_erase_enable;
    key_state_t key;
    op_state_t op;
    logic [PAGE_AW-1:0] erase_cnt;
    logic [FLASH_AW-1:0] op_addr;
    logic [7:0] op_data;
    logic refused;
    logic key_error;
    logic ack;
    logic [31:0] dat;
    logic xd_we;
    logic [FLASH_AW-1:0] xd_addr;
    logic [7:0] xd_data;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic fl_we;
  logic fl_and;
  logic [FLASH_AW-1:0] fl_addr;
  logic [7:0] fl_data;
  logic [FLASH_AW-1:0] win_addr;
  logic [7:0] fl_rd_data;
  logic req;
  logic in_window;
  logic refused_set;
  logic key_err_set;
  logic refused_clr;
  logic key_err_clr;

  function automatic logic reg_hit(input logic [31:0] adr, input logic [11:0] off);
    reg_hit = (adr[WINDOW_BIT] == 1'b0) && (adr[11:2] == off[11:2]);
  endfunction : reg_hit

  function automatic logic [1:0] key_progress(input key_state_t k);
    logic [1:0] p;
    p = KEYS_NONE;
    if (k == KEY_HALF) begin
      p = KEYS_ONE;
    end else if (k == KEY_OPEN) begin
      p = KEYS_BOTH;
    end
    key_progress = p;
  endfunction : key_progress

  assign win_addr = adr_i[WIN_LSB+FLASH_AW-1:WIN_LSB];
  assign in_window = adr_i[WINDOW_BIT];
  // A request is taken only while no flash operation runs and no answer is pending.
  assign req = cyc_i && stb_i && !s_reg.ack && (s_reg.op == OP_IDLE);

  // Flash write port is driven from state, so the array sees stable values.
  assign fl_we = (s_reg.op != OP_IDLE);
  assign fl_and = (s_reg.op == OP_PROG);
  assign fl_addr = (s_reg.op == OP_ERASE) ?
                   {s_reg.op_addr[FLASH_AW-1:PAGE_AW], s_reg.erase_cnt} : s_reg.op_addr;
  assign fl_data = (s_reg.op == OP_ERASE) ? ERASED_BYTE : s_reg.op_data;

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.xd_we = 1'b0;
    refused_set = 1'b0;
    key_err_set = 1'b0;
    refused_clr = 1'b0;
    key_err_clr = 1'b0;
    unique case (s_reg.op)
      OP_PROG: begin
        s_next.op = OP_IDLE;
        s_next.ack = 1'b1;
      end
      OP_ERASE: begin
        // One byte per cycle keeps the array a plain memory with a single write port.
        s_next.erase_cnt = s_reg.erase_cnt + 9'h001;
        if (s_reg.erase_cnt == PAGE_LAST) begin
          s_next.op = OP_IDLE;
          s_next.ack = 1'b1;
        end
      end
      OP_IDLE: begin
        if (req) begin
          s_next.dat = 32'h0000_0000;
          if (in_window) begin
            if (!we_i) begin
              s_next.dat = {24'h00_0000, fl_rd_data};
              s_next.ack = 1'b1;
            end else if (!sel_i[0]) begin
              s_next.ack = 1'b1;
            end else if (s_reg.store_write_enable) begin
              if (s_reg.key == KEY_OPEN) begin
                s_next.key = KEY_LOCKED;
                s_next.op_addr = win_addr;
                s_next.op_data = dat_i[7:0];
                if (s_reg.page_erase_enable) begin
                  s_next.op = OP_ERASE;
                  s_next.erase_cnt = '0;
                end else begin
                  s_next.op = OP_PROG;
                end
              end else begin
                refused_set = 1'b1;
                s_next.ack = 1'b1;
              end
            end else begin
              s_next.xd_we = 1'b1;
              s_next.xd_addr = win_addr;
              s_next.xd_data = dat_i[7:0];
              s_next.ack = 1'b1;
            end
          end else begin
            s_next.ack = 1'b1;
            if (reg_hit(adr_i, PSC_OFFSET)) begin
              if (we_i && sel_i[0]) begin
                // Only a software write changes either enable bit.
                s_next.store_write_enable = dat_i[SWE_BIT];
                s_next.page_erase_enable = dat_i[PEE_BIT];
              end
              s_next.dat[SWE_BIT] = s_reg.store_write_enable;
              s_next.dat[PEE_BIT] = s_reg.page_erase_enable;
            end else if (reg_hit(adr_i, KEY_OFFSET)) begin
              if (we_i && sel_i[0]) begin
                unique case (s_reg.key)
                  KEY_LOCKED: begin
                    if (dat_i[7:0] == KEY_FIRST) begin
                      s_next.key = KEY_HALF;
                    end else begin
                      key_err_set = 1'b1;
                    end
                  end
                  KEY_HALF: begin
                    if (dat_i[7:0] == KEY_SECOND) begin
                      s_next.key = KEY_OPEN;
                    end else begin
                      s_next.key = KEY_LOCKED;
                      key_err_set = 1'b1;
                    end
                  end
                  KEY_OPEN: begin
                    // A third key write is out of order and withdraws the unlock.
                    s_next.key = KEY_LOCKED;
                    key_err_set = 1'b1;
                  end
                endcase
              end
              s_next.dat[1:0] = key_progress(s_reg.key);
            end else if (reg_hit(adr_i, STATUS_OFFSET)) begin
              if (we_i && sel_i[0]) begin
                refused_clr = dat_i[ST_REFUSED_BIT];
                key_err_clr = dat_i[ST_KEY_ERR_BIT];
              end
              s_next.dat[1:0] = key_progress(s_reg.key);
              s_next.dat[ST_REFUSED_BIT] = s_reg.refused;
              s_next.dat[ST_KEY_ERR_BIT] = s_reg.key_error;
            end
          end
        end
      end
    endcase
    // A new event in the cycle of its clear keeps the flag set.
    s_next.refused = (s_reg.refused && !refused_clr) || refused_set;
    s_next.key_error = (s_reg.key_error && !key_err_clr) || key_err_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg.store_write_enable <= PSC_RESET[SWE_BIT];
      s_reg.page_erase_enable <= PSC_RESET[PEE_BIT];
      s_reg.key <= KEY_LOCKED;
      s_reg.op <= OP_IDLE;
      s_reg.erase_cnt <= '0;
      s_reg.op_addr <= '0;
      s_reg.op_data <= 8'h00;
      s_reg.refused <= 1'b0;
      s_reg.key_error <= 1'b0;
      s_reg.ack <= 1'b0;
      s_reg.dat <= 32'h0000_0000;
      s_reg.xd_we <= 1'b0;
      s_reg.xd_addr <= '0;
      s_reg.xd_data <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  flash_store u_store (
    .clk_i(clk_i),
    .we_i(fl_we),
    .and_i(fl_and),
    .addr_i(fl_addr),
    .data_i(fl_data),
    .rd_addr_i(win_addr),
    .rd_data_o(fl_rd_data)
  );

  assign dat_o = s_reg.dat;
  assign ack_o = s_reg.ack;
  assign xdata_we_o = s_reg.xd_we;
  assign xdata_addr_o = s_reg.xd_addr;
  assign xdata_data_o = s_reg.xd_data;
  assign store_write_enable_o = s_reg.store_write_enable;
  assign flash_busy_o = (s_reg.op != OP_IDLE);

endmodule : flash_page_erase_byte_write

// ### core/flash_seq_pkg.sv
// Overview of operation
// - Store-write enable set sends external data writes to flash, not data memory.
// - Key bytes 0xa5 then 0xf1 must precede any flash write or erase.
// - Store-write enable stays set until software writes it to zero.
// - Byte programming stores old AND new; only erase returns bits to one.
// - Flash is split into 512-byte pages; erase fills a page with 0xff.
// - Erase enable plus write enable plus keys: any page write erases page.
// - Write enable set, erase enable clear: one write programs one byte.
// - One key pair unlocks one modification; the block relocks after it.
package flash_seq_pkg;

  localparam int FLASH_AW = 11;
  localparam int FLASH_BYTES = 2048;
  localparam int PAGE_AW = 9;
  localparam logic [PAGE_AW-1:0] PAGE_LAST = 9'h1ff;

  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Register word offsets (byte addresses) below the external data window.
  localparam logic [11:0] PSC_OFFSET = 12'h000;
  localparam logic [11:0] KEY_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  // Byte address bit that selects the external data window; word index is the address.
  localparam int WINDOW_BIT = 13;
  localparam int WIN_LSB = 2;

  localparam int SWE_BIT = 0;
  localparam int PEE_BIT = 1;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_KEY_ERR_BIT = 3;

  localparam logic [1:0] KEYS_NONE = 2'h0;
  localparam logic [1:0] KEYS_ONE = 2'h1;
  localparam logic [1:0] KEYS_BOTH = 2'h2;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'b001,
    KEY_HALF = 3'b010,
    KEY_OPEN = 3'b100
  } key_state_t;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_PROG = 3'b010,
    OP_ERASE = 3'b100
  } op_state_t;

endpackage : flash_seq_pkg

// ### core/flash_store.sv
`timescale 1ns/10ps
module flash_store
  import flash_seq_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic we_i, // Write strobe for one byte.
  input wire logic and_i, // 1: program (AND with old), 0: plain store.
  input wire logic [FLASH_AW-1:0] addr_i, // Write address.
  input wire logic [7:0] data_i, // Write data.
  input wire logic [FLASH_AW-1:0] rd_addr_i, // Read address.
  output logic [7:0] rd_data_o // Read data, asynchronous.
);

  // Cell contents are not reset, just as real flash keeps its contents.
  logic [7:0] mem [FLASH_BYTES];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= and_i ? (mem[addr_i] & data_i) : data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];

endmodule : flash_store

// ### bench/flash_seq_properties.sv
`timescale 1ns/10ps
module flash_seq_properties
  import flash_seq_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic cyc_i, // Cycle.
  input wire logic stb_i, // Strobe.
  input wire logic we_i, // Write.
  input wire logic [31:0] adr_i, // Address.
  input wire logic [3:0] sel_i, // Lanes.
  input wire logic [31:0] dat_i, // Write data.
  input wire logic ack_o, // Acknowledge.
  input wire logic xdata_we_o, // Data strobe.
  input wire logic [FLASH_AW-1:0] xdata_addr_o, // Data address.
  input wire logic [7:0] xdata_data_o, // Data byte.
  input wire logic store_write_enable_o, // Enable.
  input wire logic flash_busy_o // Busy.
);
  logic [9:0] busy_cnt_reg;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Counts busy cycles so a program and an erase can be told apart by length alone.
  always_ff @(posedge clk_i) begin
    busy_cnt_reg <= (rst_i || !flash_busy_o) ? 10'h0 : busy_cnt_reg + 10'h1;
  end
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_REQ_LATENCY: assert property (cyc_i && stb_i && !ack_o && !flash_busy_o
    && !(we_i && adr_i[13] && store_write_enable_o) |=> ack_o) else $error("late ack");
  AST_SWE_CHANGE: assert property ($changed(store_write_enable_o) && !$past(rst_i) |->
    ack_o && we_i && adr_i[13:2] == 12'h0 && store_write_enable_o == dat_i[0])
    else $error("enable moved");
  AST_XDATA_ROUTE: assert property (xdata_we_o |-> ack_o && we_i && adr_i[13]
    && !store_write_enable_o && xdata_addr_o == adr_i[12:2] && xdata_data_o == dat_i[7:0])
    else $error("bad data write");
  AST_XDATA_GATE: assert property (ack_o && we_i && adr_i[13] && sel_i[0]
    && !store_write_enable_o |-> xdata_we_o) else $error("data write lost");
  AST_BUSY_CAUSE: assert property ($rose(flash_busy_o) |-> $past(cyc_i && stb_i && we_i
    && adr_i[13] && sel_i[0] && store_write_enable_o)) else $error("busy uncaused");
  AST_BUSY_LEN: assert property ($fell(flash_busy_o) && !$past(rst_i) |-> ack_o
    && (busy_cnt_reg == 10'h1 || busy_cnt_reg == 10'h200)) else $error("busy length");
  AST_BUSY_NO_ACK: assert property (flash_busy_o |-> !ack_o ##1 (ack_o || flash_busy_o))
    else $error("ack while busy");
  cover property ($fell(flash_busy_o) && busy_cnt_reg == 10'h200);
  cover property ($fell(flash_busy_o) && busy_cnt_reg == 10'h1);
  cover property (xdata_we_o);
endmodule : flash_seq_properties
bind flash_page_erase_byte_write flash_seq_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .ack_o(ack_o), .xdata_we_o(xdata_we_o), .xdata_addr_o(xdata_addr_o),
  .xdata_data_o(xdata_data_o), .store_write_enable_o(store_write_enable_o),
  .flash_busy_o(flash_busy_o));

// ### bench/core_model.sv
`timescale 1ns/10ps
module core_model
  import flash_seq_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic ack_i, // Acknowledge.
  input wire logic [31:0] dat_i, // Read data.
  output logic cyc_o, // Cycle.
  output logic stb_o, // Strobe.
  output logic we_o, // Write.
  output logic [31:0] adr_o, // Address.
  output logic [3:0] sel_o, // Lanes.
  output logic [31:0] dat_o // Write data.
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  function automatic logic [31:0] win(input logic [FLASH_AW-1:0] a);
    return {18'h0, 1'b1, a, 2'h0};
  endfunction : win
  // The request stays put until ack is seen at an edge; the wait is bounded.
  // Ack is looked at mid-cycle, so the rising edge that follows is the one that samples it high.
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h1, 24'h0, d};
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 1000);
    q = dat_i;
    @(posedge clk_i);
    {cyc_o, stb_o} <= 2'b00;
  endtask : wb
  // One unlocked change; both keys, write enable set and erase enable set to er, one window write, enables cleared.
  task automatic modify(input logic [FLASH_AW-1:0] a, input logic [7:0] d, input logic er);
    logic [31:0] q;
    wb(1'b1, {20'h0, KEY_OFFSET}, KEY_FIRST, q);
    wb(1'b1, {20'h0, KEY_OFFSET}, KEY_SECOND, q);
    wb(1'b1, {20'h0, PSC_OFFSET}, {6'h0, er, 1'b1}, q);
    wb(1'b1, win(a), d, q);
    wb(1'b1, {20'h0, PSC_OFFSET}, 8'h00, q);
  endtask : modify
endmodule : core_model

// ### bench/tb_flash_page_erase_byte_write.sv
`timescale 1ns/10ps
module tb_flash_page_erase_byte_write;
  import flash_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, xwe, swe, busy;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel;
  logic [18:0] xlast;
  int errors = 0;
  int samples_checked = 0;
  int xcnt = 0;
  always #10 clk_i = ~clk_i;
  core_model cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  flash_page_erase_byte_write dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .xdata_we_o(xwe), .xdata_addr_o(xlast[18:8]), .xdata_data_o(xlast[7:0]),
    .store_write_enable_o(swe), .flash_busy_o(busy));
  // Counted mid-cycle, where the one-cycle strobe is settled.
  always @(negedge clk_i) begin
    if (xwe === 1'b1) xcnt++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    cpu.wb(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rd
  task automatic w(input logic [31:0] a, input logic [7:0] d);
    cpu.wb(1'b1, a, d, q);
  endtask : w
  task automatic t_regs();
    rd(32'h0, 32'h0);
    w(32'h00c, 8'hff);
    rd(32'h00c, 32'h0);
    rd(32'h008, 32'h0);
  endtask : t_regs
  task automatic t_route();
    w(cpu.win(11'h123), 8'h3c);
    check(32'(xcnt), 32'h1);
    check({13'h0, xlast}, {13'h0, 11'h123, 8'h3c});
  endtask : t_route
  task automatic t_erase();
    cpu.modify(11'h2ab, 8'h00, 1'b1);
    rd(cpu.win(11'h200), 32'hff);
    rd(cpu.win(11'h3ff), {24'h0, ERASED_BYTE});
    rd(32'h004, {30'h0, KEYS_NONE});
    check(32'(xcnt), 32'h1);
  endtask : t_erase
  task automatic t_program();
    cpu.modify(11'h205, 8'h5a, 1'b0);
    rd(cpu.win(11'h205), 32'h5a);
    rd(cpu.win(11'h206), 32'hff);
    cpu.modify(11'h205, 8'ha5, 1'b0);
    rd(cpu.win(11'h205), 32'h00);
  endtask : t_program
  // Keys out of order and a wrong key, then a second write on one unlock.
  task automatic t_refuse();
    w(32'h004, KEY_SECOND);
    w(32'h004, KEY_FIRST);
    w(32'h004, 8'h00);
    w(32'h000, 8'h01);
    w(cpu.win(11'h206), 8'h00);
    rd(cpu.win(11'h206), 32'hff);
    rd(32'h008, 32'h0c);
    check({31'h0, swe}, 32'h1);
    w(32'h004, KEY_FIRST);
    w(32'h004, KEY_SECOND);
    w(cpu.win(11'h207), 8'h0f);
    w(cpu.win(11'h208), 8'h00);
    rd(cpu.win(11'h207), 32'h0f);
    rd(cpu.win(11'h208), 32'hff);
    w(32'h008, 8'h0c);
    rd(32'h008, 32'h0);
    w(32'h000, 8'h00);
  endtask : t_refuse
  task automatic summarize();
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_route();
    t_erase();
    t_program();
    t_refuse();
    summarize();
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    errors++;
    summarize();
  end
endmodule : tb_flash_page_erase_byte_write
